// >>> bench/cpu_seq_model.sv
`timescale 1ns/10ps
// cpu sequencer: machine cycles of two clocks, three while a long instruction runs
module cpu_seq_model
	import irq_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire irq_ctrl_pkg::cpu_cmd_t instr,
	output irq_ctrl_pkg::cpu_cmd_t cpu_cmd
);
	logic [1:0] phase;
	// phase zero is the last clock of a machine cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			phase <= 2'h0;
		else if (phase == (slow ? 2'h2 : 2'h1))
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end
	// one instruction per machine cycle keeps the enable delay short and exact
	always_comb
	begin
		cpu_cmd = instr;
		cpu_cmd.cycle_end = (phase == 2'h0);
		cpu_cmd.instr_end = (phase == 2'h0);
		cpu_cmd.multi_cycle = slow;
	end
endmodule // cpu_seq_model

// >>> bench/vectored_interrupt_control_test.sv
`timescale 1ns/10ps
module vectored_interrupt_control_test;
	import irq_ctrl_pkg::*;
	logic clk, reset_n, hsel, hwrite, slow, hreadyout, hresp, irq;
	logic irq_take, skip_valid, skip_result, restore_valid, global_irq_enable_flag;
	// one-cycle answers caught one step after the edge that launches them
	logic sv, sr, rv;
	logic [31:0] haddr, hwdata, hrdata, rd, v;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] source_event, en;
	logic [12:0] resume_pc, irq_vector, restored_pc;
	cpu_cmd_t instr, cpu_cmd;
	cpu_ctx_t cpu_ctx, restored_ctx;
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	int i;

	vectored_interrupt_control uut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.source_event(source_event), .cpu_cmd(cpu_cmd), .cpu_ctx(cpu_ctx),
		.resume_pc(resume_pc), .irq_take(irq_take), .irq_vector(irq_vector),
		.skip_valid(skip_valid), .skip_result(skip_result), .restore_valid(restore_valid),
		.restored_pc(restored_pc), .restored_ctx(restored_ctx),
		.global_irq_enable_flag(global_irq_enable_flag), .irq(irq));
	cpu_seq_model partner (.clk(clk), .reset_n(reset_n), .slow(slow), .instr(instr),
		.cpu_cmd(cpu_cmd));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// a hang is cut short well past the few hundred cycles the run needs
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			results;
		end
	end

	task automatic results;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one single word transfer; read data taken at the edge closing the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	function automatic cpu_cmd_t cmd(input int k, input logic [2:0] s);
		cmd = '0;
		cmd.enable_irq_instr = (k == 0);
		cmd.disable_irq_instr = (k == 1);
		cmd.return_from_irq_instr = (k == 2);
		cmd.skip_instr = (k == 3);
		cmd.skip_src = s;
	endfunction

	// instruction placed in the last clock of a machine cycle, so it ends there;
	// the pulse answers stand one cycle only, so they are latched when settled
	task automatic op(input cpu_cmd_t c);
		do
		begin
			@(posedge clk);
			#1;
		end
		while (!cpu_cmd.cycle_end);
		instr <= c;
		@(posedge clk);
		instr <= '0;
		#1;
		sv = skip_valid;
		sr = skip_result;
		rv = restore_valid;
		@(posedge clk);
		#1;
	endtask

	task automatic ev(input logic [7:0] m);
		source_event <= m;
		@(posedge clk);
		source_event <= 8'h00;
		@(posedge clk);
	endtask

	// counts machine cycles with the global enable up until the entry pulse
	task automatic take(input int lat, input logic [12:0] vec);
		int n;
		int k;
		n = 0;
		for (k = 0; k < 40 && irq_take !== 1'b1; k++)
		begin
			@(posedge clk);
			#1;
			if (cpu_cmd.cycle_end && global_irq_enable_flag)
				n++;
		end
		chk(32'(n), 32'(lat));
		chk(irq_vector, vec);
	endtask

	initial
	begin
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		source_event = 8'h00;
		instr = '0;
		cpu_ctx = '0;
		resume_pc = 13'h0000;
		slow = 1'b0;
		void'($urandom(11961));
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		// every register starts at zero, the unmapped word reads zero
		for (i = 0; i < 7; i++)
		begin
			bus(1'b0, (i == 6) ? 8'h40 : 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		chk(hresp, HRESP_OKAY);
		for (i = 0; i < 8; i++)
		begin
			v = $urandom;
			bus(1'b1, i[0] ? REG_ENABLE_SECOND : REG_ENABLE_FIRST, v);
			bus(1'b0, i[0] ? REG_ENABLE_SECOND : REG_ENABLE_FIRST, 32'h0);
			chk(rd, v & 32'hF);
		end
		$display("register test done");
		// only the tested source has its enable clear, so a wrong pairing shows
		for (i = 0; i < 8; i++)
		begin
			en = ~(8'h01 << i);
			bus(1'b1, REG_ENABLE_FIRST, {28'h0, en[3:0]});
			bus(1'b1, REG_ENABLE_SECOND, {28'h0, en[7:4]});
			ev(8'h01 << i);
			bus(1'b0, REG_REQUEST, 32'h0);
			chk(rd, 32'h1 << i);
			op(cmd(3, i[2:0]));
			chk(sv, 1'b1);
			chk(sr, 1'b1);
			bus(1'b0, REG_REQUEST, 32'h0);
			chk(rd, 32'h0);
		end
		$display("skip test done");
		op(cmd(0, 3'h0));
		chk(global_irq_enable_flag, 1'b0);
		repeat (4) @(posedge clk);
		chk(global_irq_enable_flag, 1'b1);
		op(cmd(1, 3'h0));
		chk(global_irq_enable_flag, 1'b0);
		// all sources pend while blocked; enabled sources make skips ineffective
		bus(1'b1, REG_ENABLE_FIRST, 32'hF);
		bus(1'b1, REG_ENABLE_SECOND, 32'hF);
		ev(8'hFF);
		for (i = 0; i < 8; i++)
		begin
			op(cmd(3, i[2:0]));
			chk(sv, 1'b1);
			chk(sr, 1'b0);
		end
		chk(irq_take, 1'b0);
		bus(1'b0, REG_REQUEST, 32'h0);
		chk(rd, 32'hFF);
		$display("enable test done");
		// each release serves the highest pending source; index 3 runs long
		for (i = 0; i < 8; i++)
		begin
			slow <= (i == 3);
			resume_pc <= 13'($urandom);
			cpu_ctx <= 19'($urandom);
			op(cmd(0, 3'h0));
			chk(global_irq_enable_flag, 1'b0);
			take((i == 3) ? 3 : 2, VECTOR_BASE + 13'(2 * i));
			chk(global_irq_enable_flag, 1'b0);
			bus(1'b0, REG_REQUEST, 32'h0);
			chk(rd, 32'hFF & (32'hFF << (i + 1)));
			op(cmd(2, 3'h0));
			chk(rv, 1'b1);
			chk(restored_pc, resume_pc);
			chk(restored_ctx, cpu_ctx);
		end
		$display("entry test done");
		// sticky status, masked into the level output, cleared by writing ones
		bus(1'b0, REG_EVENT_STATUS, 32'h0);
		chk(rd, 32'hFF);
		chk(irq, 1'b0);
		bus(1'b1, REG_EVENT_MASK, 32'h7F);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		bus(1'b1, REG_EVENT_STATUS, 32'h7F);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		ev(8'h80);
		@(posedge clk);
		chk(irq, 1'b0);
		ev(8'h01);
		@(posedge clk);
		chk(irq, 1'b1);
		bus(1'b0, REG_EVENT_STATUS, 32'h0);
		chk(rd, 32'h81);
		$display("status test done");
		results;
	end
endmodule // vectored_interrupt_control_test

// >>> logic/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
	localparam int SRC_COUNT = 8;
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 3;
	localparam int HALF_W = 4;
	// vectors start at address 0 of page 1, two words apart
	localparam logic [12:0] VECTOR_BASE = 13'h0080;
	localparam logic [2:0] STACK_PTR_RESET = 3'h7;
	// machine cycles from condition to entry
	localparam logic [1:0] LAT_SHORT = 2'h2;
	localparam logic [1:0] LAT_LONG = 2'h3;
	localparam logic [1:0] LAT_ONE = 2'h1;
	localparam logic [3:0] ENABLE_RESET = 4'h0;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// register byte offsets
	localparam logic [7:0] REG_ENABLE_FIRST = 8'h00;
	localparam logic [7:0] REG_ENABLE_SECOND = 8'h04;
	localparam logic [7:0] REG_REQUEST = 8'h08;
	localparam logic [7:0] REG_EVENT_STATUS = 8'h0C;
	localparam logic [7:0] REG_EVENT_MASK = 8'h10;
	localparam logic [7:0] REG_STATE = 8'h14;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} take_state_t;

	typedef struct packed {
		logic [8:0] data_pointer;
		logic carry_flag;
		logic skip_flag;
		logic [3:0] acc;
		logic [3:0] breg;
	} cpu_ctx_t;

	typedef struct packed {
		logic enable_irq_instr;
		logic disable_irq_instr;
		logic return_from_irq_instr;
		logic skip_instr;
		logic [2:0] skip_src;
		logic instr_end;
		logic cycle_end;
		logic multi_cycle;
	} cpu_cmd_t;
endpackage

// >>> logic/return_stack_mem.sv
`timescale 1ns/10ps
// small stack array, read data comes out of a register
module return_stack_mem (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [irq_ctrl_pkg::SP_W-1:0] wr_addr,
	input wire logic [irq_ctrl_pkg::PC_W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [irq_ctrl_pkg::SP_W-1:0] rd_addr,
	output logic [irq_ctrl_pkg::PC_W-1:0] rd_data
);
	import irq_ctrl_pkg::*;
	logic [PC_W-1:0] mem [STACK_DEPTH];

	// storage is not reset, software never reads an empty slot
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// registered read port
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_data <= '0;
		else if (rd_en)
			rd_data <= mem[rd_addr];
	end
endmodule // return_stack_mem

// >>> logic/vectored_interrupt_control.sv
`timescale 1ns/10ps
module vectored_interrupt_control (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [irq_ctrl_pkg::SRC_COUNT-1:0] source_event,
	input wire irq_ctrl_pkg::cpu_cmd_t cpu_cmd,
	input wire irq_ctrl_pkg::cpu_ctx_t cpu_ctx,
	input wire logic [irq_ctrl_pkg::PC_W-1:0] resume_pc,
	output logic irq_take,
	output logic [irq_ctrl_pkg::PC_W-1:0] irq_vector,
	output logic skip_valid,
	output logic skip_result,
	output logic restore_valid,
	output logic [irq_ctrl_pkg::PC_W-1:0] restored_pc,
	output irq_ctrl_pkg::cpu_ctx_t restored_ctx,
	output logic global_irq_enable_flag,
	output logic irq
);
	import irq_ctrl_pkg::*;

	logic [HALF_W-1:0] irq_enable_reg_first;
	logic [HALF_W-1:0] irq_enable_reg_second;
	logic [SRC_COUNT-1:0] request_flag;
	logic [SRC_COUNT-1:0] event_status;
	logic [SRC_COUNT-1:0] event_mask;
	logic [SRC_COUNT-1:0] enable_bits;
	logic [SRC_COUNT-1:0] active;
	logic [SRC_COUNT-1:0] take_clear;
	logic [SRC_COUNT-1:0] skip_clear;
	logic [SRC_COUNT-1:0] status_w1c;
	logic cond;
	logic ei_armed;
	logic take_now;
	logic [2:0] winner;
	logic skip_hit;
	take_state_t state;
	logic [1:0] lat_count;
	logic [SP_W-1:0] stack_ptr;
	cpu_ctx_t irq_context_save_reg;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic bus_write;

	// bit order pairs flag, skip test and enable bit per source
	assign enable_bits = {irq_enable_reg_second, irq_enable_reg_first};
	assign active = request_flag & enable_bits;
	assign cond = global_irq_enable_flag & (|active);

	// lowest index is the highest level; adc sits at index 6
	always_comb
	begin
		winner = '0;
		for (int i = SRC_COUNT - 1; i >= 0; i--)
			if (active[i])
				winner = 3'(i);
	end

	assign take_now = (state == ST_WAIT) && cpu_cmd.cycle_end && (lat_count == LAT_ONE) && cond;
	assign take_clear = take_now ? 8'(8'h01 << winner) : FLAGS_RESET;
	assign skip_hit = cpu_cmd.skip_instr && request_flag[cpu_cmd.skip_src] &&
		!enable_bits[cpu_cmd.skip_src];
	assign skip_clear = skip_hit ? 8'(8'h01 << cpu_cmd.skip_src) : FLAGS_RESET;
	assign bus_write = wr_pend;
	assign status_w1c = (bus_write && wr_addr == REG_EVENT_STATUS) ? hwdata[SRC_COUNT-1:0] :
		FLAGS_RESET;

	// per source request flag and sticky event bit; a new event beats any clear
	generate
		for (genvar g = 0; g < SRC_COUNT; g++)
		begin : g_src
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
					request_flag[g] <= 1'b0;
				else if (source_event[g])
					request_flag[g] <= 1'b1;
				else if (take_clear[g] || skip_clear[g])
					request_flag[g] <= 1'b0;
			end

			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
					event_status[g] <= 1'b0;
				else if (source_event[g])
					event_status[g] <= 1'b1;
				else if (status_w1c[g])
					event_status[g] <= 1'b0;
			end
		end
	endgenerate

	// enable is armed first and lands after the next instruction ends
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ei_armed <= 1'b0;
		else if (take_now || cpu_cmd.disable_irq_instr)
			ei_armed <= 1'b0;
		else if (cpu_cmd.enable_irq_instr)
			ei_armed <= 1'b1;
		else if (cpu_cmd.instr_end)
			ei_armed <= 1'b0;
	end

	// global enable; entry has priority over a pending enable
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			global_irq_enable_flag <= 1'b0;
		else if (take_now)
			global_irq_enable_flag <= 1'b0;
		else if (cpu_cmd.disable_irq_instr)
			global_irq_enable_flag <= 1'b0;
		else if (ei_armed && cpu_cmd.instr_end && !cpu_cmd.enable_irq_instr)
			global_irq_enable_flag <= 1'b1;
	end

	// latency counter in machine cycles; a drop of the condition cancels
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= ST_IDLE;
			lat_count <= '0;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (cond)
					begin
						state <= ST_WAIT;
						lat_count <= cpu_cmd.multi_cycle ? LAT_LONG : LAT_SHORT;
					end
				end
				ST_WAIT:
				begin
					if (!cond || take_now)
						state <= ST_IDLE;
					else if (cpu_cmd.cycle_end)
						lat_count <= lat_count - LAT_ONE;
				end
			endcase
		end
	end

	// entry outputs: vector and one-cycle take strobe
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_take <= 1'b0;
			irq_vector <= '0;
		end
		else
		begin
			irq_take <= take_now;
			if (take_now)
				irq_vector <= VECTOR_BASE + PC_W'({winner, 1'b0});
		end
	end

	// single-stage context save; a nested entry overwrites it
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			irq_context_save_reg <= '0;
		else if (take_now)
			irq_context_save_reg <= cpu_ctx;
	end

	// stack pointer wraps past eight levels, oldest entry is lost
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			stack_ptr <= STACK_PTR_RESET;
		else if (take_now)
			stack_ptr <= stack_ptr + 3'h1;
		else if (cpu_cmd.return_from_irq_instr)
			stack_ptr <= stack_ptr - 3'h1;
	end

	return_stack_mem u_return_stack_reg (
		.clk(clk),
		.reset_n(reset_n),
		.wr_en(take_now),
		.wr_addr(stack_ptr + 3'h1),
		.wr_data(resume_pc),
		.rd_en(cpu_cmd.return_from_irq_instr && !take_now),
		.rd_addr(stack_ptr),
		.rd_data(restored_pc)
	);

	// each return loads the saved context; the address is popped with it unless an entry falls in the same cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			restore_valid <= 1'b0;
			restored_ctx <= '0;
		end
		else
		begin
			restore_valid <= cpu_cmd.return_from_irq_instr && !take_now;
			if (cpu_cmd.return_from_irq_instr)
				restored_ctx <= irq_context_save_reg;
		end
	end

	// skip test answer, one cycle after the request
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			skip_valid <= 1'b0;
			skip_result <= 1'b0;
		end
		else
		begin
			skip_valid <= cpu_cmd.skip_instr;
			skip_result <= skip_hit;
		end
	end

	// bus slave: zero wait states, write data applied in data phase
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end
		else
		begin
			wr_pend <= hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// enable registers written by software steer the take logic; the mask only gates irq
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_enable_reg_first <= ENABLE_RESET;
			irq_enable_reg_second <= ENABLE_RESET;
			event_mask <= FLAGS_RESET;
		end
		else if (bus_write)
		begin
			if (wr_addr == REG_ENABLE_FIRST)
				irq_enable_reg_first <= hwdata[HALF_W-1:0];
			if (wr_addr == REG_ENABLE_SECOND)
				irq_enable_reg_second <= hwdata[HALF_W-1:0];
			if (wr_addr == REG_EVENT_MASK)
				event_mask <= hwdata[SRC_COUNT-1:0];
		end
	end

	// read data registered at the address phase; unmapped reads zero
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hrdata <= '0;
		else if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite)
		begin
			unique case (haddr[7:0])
				REG_ENABLE_FIRST: hrdata <= 32'(irq_enable_reg_first);
				REG_ENABLE_SECOND: hrdata <= 32'(irq_enable_reg_second);
				REG_REQUEST: hrdata <= 32'(request_flag);
				REG_EVENT_STATUS: hrdata <= 32'(event_status);
				REG_EVENT_MASK: hrdata <= 32'(event_mask);
				REG_STATE: hrdata <= 32'({ei_armed, global_irq_enable_flag});
				default: hrdata <= '0;
			endcase
		end
	end

	// constant handshake, kept in flops so outputs are registered
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
	end

	// interrupt line to the system, lags the status by one cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			irq <= 1'b0;
		else
			irq <= |(event_status & event_mask);
	end

	// checks
	property p_take_cond;
		@(posedge clk) disable iff (!reset_n)
		irq_take |-> $past(cond);
	endproperty
	a_take_cond: assert property (p_take_cond) else $error("entry without condition");

	property p_take_clears_enable;
		@(posedge clk) disable iff (!reset_n)
		irq_take |-> !global_irq_enable_flag;
	endproperty
	a_take_clears_enable: assert property (p_take_clears_enable)
		else $error("global enable still set after entry");

	property p_disable;
		@(posedge clk) disable iff (!reset_n)
		cpu_cmd.disable_irq_instr |=> !global_irq_enable_flag;
	endproperty
	a_disable: assert property (p_disable) else $error("disable did not clear");

	property p_enable_delay;
		@(posedge clk) disable iff (!reset_n)
		(cpu_cmd.enable_irq_instr && !global_irq_enable_flag) |=> !global_irq_enable_flag;
	endproperty
	a_enable_delay: assert property (p_enable_delay) else $error("enable took effect early");

	property p_event_sets;
		@(posedge clk) disable iff (!reset_n)
		(source_event != '0) |=> ((request_flag & $past(source_event)) == $past(source_event));
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event did not set flag");

	property p_skip;
		@(posedge clk) disable iff (!reset_n)
		cpu_cmd.skip_instr |=> skip_valid && (skip_result == $past(skip_hit)) &&
			(!skip_result || $past(source_event[cpu_cmd.skip_src]) ||
			!request_flag[$past(cpu_cmd.skip_src)]);
	endproperty
	a_skip: assert property (p_skip) else $error("skip test wrong");

	property p_vector;
		@(posedge clk) disable iff (!reset_n)
		irq_take |-> (irq_vector == VECTOR_BASE + PC_W'({$past(winner), 1'b0}));
	endproperty
	a_vector: assert property (p_vector) else $error("wrong vector");

	property p_only_served;
		@(posedge clk) disable iff (!reset_n)
		irq_take |-> (((request_flag ^ $past(request_flag)) & ~$past(source_event) &
			~$past(take_clear)) == '0) && ((request_flag & $past(take_clear) &
			~$past(source_event)) == '0);
	endproperty
	a_only_served: assert property (p_only_served) else $error("wrong flag cleared");

	property p_priority;
		@(posedge clk) disable iff (!reset_n)
		irq_take |-> (($past(active) & 8'(($past(take_clear)) - 8'h01)) == '0);
	endproperty
	a_priority: assert property (p_priority) else $error("lower level served first");

	c_take: cover property (@(posedge clk) disable iff (!reset_n) irq_take);
	c_skip_hit: cover property (@(posedge clk) disable iff (!reset_n) skip_valid && skip_result);
	c_return: cover property (@(posedge clk) disable iff (!reset_n) restore_valid);
	c_long_wait: cover property (@(posedge clk) disable iff (!reset_n)
		(state == ST_IDLE) && cond && cpu_cmd.multi_cycle);
endmodule // vectored_interrupt_control
